// [video_timing_pkg.sv]
/*
  Shared constants and types for the enable-only video link:
  frame and line totals, rate limits, screen size and panel states.
  Assumes one system clock of 125 MHz on both ends of the link.
*/
// Contract
// - every frame is exactly 1120 lines
// - 1080 active lines then 40 blank lines
// - every line is exactly 1060 pixel clocks
// - 960 active clocks then 100 blank clocks
// - pixel clock between 53 and 82 MHz
// - frame rate between 47 and 63 Hz
// - line rate between 60 and 73 kHz; the source's 62.5 MHz pixel clock over 1060 clocks gives about 58.96 kHz
// - placement comes only from strobe rising edges
// - first pixel after strobe rise is leftmost
// - rise after eight low lines starts frame
// - first line of frame is top row
// - uncovered screen area is filled black
// - strobe window matches valid pixel data exactly; on an underrun the source keeps the strobe high and sends black
// - each colour is 8-bit, zero is black
`default_nettype none
package video_timing_pkg;
  // ==========================================================
  // rates
  localparam int SYS_CLK_KHZ   = 125000;
  localparam int PIX_MIN_KHZ   = 53000;
  localparam int PIX_NOM_KHZ   = 74250;
  localparam int PIX_MAX_KHZ   = 82000;
  localparam int FRAME_MIN_HZ  = 47;
  localparam int FRAME_NOM_HZ  = 60;
  localparam int FRAME_MAX_HZ  = 63;
  localparam int LINE_MIN_HZ   = 60000;
  localparam int LINE_NOM_HZ   = 67500;
  localparam int LINE_MAX_HZ   = 73000;
  // half period of the divided pixel clock, rounded up so it never exceeds the maximum
  localparam int PCLK_HALF_CYC = (SYS_CLK_KHZ + 2 * PIX_MAX_KHZ - 1) / (2 * PIX_MAX_KHZ);
  // ==========================================================
  // frame geometry
  localparam int FRAME_LINES   = 1120;
  localparam int ACTIVE_LINES  = 1080;
  localparam int VBLANK_LINES  = 40;
  localparam int LINE_CLOCKS   = 1060;
  localparam int ACTIVE_CLOCKS = 960;
  localparam int HBLANK_CLOCKS = 100;
  localparam int GAP_LINES     = 8;
  localparam int GAP_CLOCKS    = GAP_LINES * LINE_CLOCKS;
  localparam int SCREEN_COLS   = 3840;
  localparam int SCREEN_ROWS   = 2160;
  // ==========================================================
  // widths and reset values
  localparam int COMP_W        = 8;
  localparam int PIX_W         = 3 * COMP_W;
  localparam int CNT_W         = 11;
  localparam int POS_W         = 12;
  localparam int GAP_W         = 16;
  localparam int DIV_W         = 8;
  localparam int SRC_RESET_H   = 0;
  // reset parks the raster this many lines past the first blank one
  localparam int SRC_RESET_V   = 0;
  localparam logic [PIX_W-1:0] BLACK = 24'h000000;
  // ==========================================================
  // panel states
  typedef enum logic [2:0] {
    ST_SEEK = 3'b001,
    ST_RUN  = 3'b010,
    ST_FILL = 3'b100
  } panel_state_t;
endpackage
`default_nettype wire

// [video_link_if.sv]
/*
  The pixel link between a video source and the panel.
  Assumes both ends sample and drive it from the same system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface video_link_if import video_timing_pkg::*; ();
  logic             pixel_clock;
  logic             pixel_valid_strobe;
  logic [PIX_W-1:0] pixel_data;
  modport source (output pixel_clock, output pixel_valid_strobe, output pixel_data);
  modport panel  (input pixel_clock, input pixel_valid_strobe, input pixel_data);
endinterface
`default_nettype wire

// [video_source.sv]
/*
  Source end of the link: divides the system clock into the pixel clock,
  walks the fixed frame raster and sends buffered user pixels in the active area.
  Assumes the user feeds pixels through valid/ready on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module video_source import video_timing_pkg::*; #(
  parameter int LINE_CLK  = LINE_CLOCKS,
  parameter int ACT_CLK   = ACTIVE_CLOCKS,
  parameter int FRAME_LN  = FRAME_LINES,
  parameter int ACT_LN    = ACTIVE_LINES,
  parameter int PCLK_HALF = PCLK_HALF_CYC
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic             run,
  input  wire logic [PIX_W-1:0] in_data,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  output var  logic             frame_start,
  output var  logic             underrun,
  video_link_if.source          link
);
  // ==========================================================
  // elaboration checks
  if (LINE_CLK >= (1 << CNT_W) || FRAME_LN >= (1 << CNT_W)) begin : g_bad_cnt
    $error("raster counts exceed counter width");
  end
  if (ACT_CLK < 1 || ACT_CLK >= LINE_CLK || ACT_LN < 1 || ACT_LN >= FRAME_LN) begin : g_bad_act
    $error("active area must be smaller than the raster");
  end
  if (PCLK_HALF < 1 || PCLK_HALF > (1 << DIV_W)) begin : g_bad_div
    $error("pixel clock divider out of range");
  end
  // the divided clock must stay in band, and the frame rate too when the raster has its full default counts
  if (SYS_CLK_KHZ / (2 * PCLK_HALF) < PIX_MIN_KHZ ||
      SYS_CLK_KHZ / (2 * PCLK_HALF) > PIX_MAX_KHZ) begin : g_bad_pclk
    $error("pixel clock out of band");
  end
  if (FRAME_LN == FRAME_LINES && LINE_CLK == LINE_CLOCKS &&
      ((SYS_CLK_KHZ / (2 * PCLK_HALF)) * 1000 / (LINE_CLK * FRAME_LN) < FRAME_MIN_HZ ||
       (SYS_CLK_KHZ / (2 * PCLK_HALF)) * 1000 / (LINE_CLK * FRAME_LN) > FRAME_MAX_HZ))
  begin : g_bad_frame
    $error("frame rate out of band");
  end

  // ==========================================================
  // pixel clock divider
  logic [DIV_W-1:0] div_cnt_r;
  logic             pclk_r;
  wire              tick = div_cnt_r == DIV_W'(PCLK_HALF - 1);
  // data moves on the falling edge so it is steady at the rising edge
  wire              fall = tick & pclk_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_r <= '0;
      pclk_r    <= 1'b0;
    end else begin
      div_cnt_r <= tick ? '0 : div_cnt_r + 1'b1;
      pclk_r    <= pclk_r ^ tick;
    end
  end

  // ==========================================================
  // raster position
  logic [CNT_W-1:0] h_r;
  logic [CNT_W-1:0] v_r;
  logic             running_r;
  logic             strobe_r;
  logic [PIX_W-1:0] data_r;
  wire              h_wrap      = h_r == CNT_W'(LINE_CLK - 1);
  wire              v_wrap      = v_r == CNT_W'(FRAME_LN - 1);
  wire              frame_begin = h_wrap & v_wrap;
  wire [CNT_W-1:0]  h_nxt       = h_wrap ? '0 : h_r + 1'b1;
  wire [CNT_W-1:0]  v_nxt       = h_wrap ? (v_wrap ? '0 : v_r + 1'b1) : v_r;
  // run is only taken at a frame boundary so no frame is ever cut short
  wire              running_nxt = frame_begin ? run : running_r;
  wire              active_nxt  = running_nxt & (h_nxt < CNT_W'(ACT_CLK)) &
                                  (v_nxt < CNT_W'(ACT_LN));

  // ==========================================================
  // two-entry input buffer
  logic [PIX_W-1:0] buf_mem [2];
  logic             wr_ptr_r;
  logic             rd_ptr_r;
  logic [1:0]       count_r;
  wire              have_word = count_r != 2'h0;
  wire              push      = in_valid & in_ready;
  wire              pop       = fall & active_nxt & have_word;
  wire [1:0]        count_nxt = 2'(count_r + {1'b0, push} - {1'b0, pop});
  // an empty buffer in the active area is sent as black, never stalls the raster
  wire [PIX_W-1:0]  word_nxt  = (active_nxt & have_word) ? buf_mem[rd_ptr_r] : BLACK;

  always_ff @(posedge clock) begin
    if (push) begin
      buf_mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r  <= 2'h0;
      in_ready <= 1'b1;
    end else begin
      wr_ptr_r <= wr_ptr_r ^ push;
      rd_ptr_r <= rd_ptr_r ^ pop;
      count_r  <= count_nxt;
      in_ready <= count_nxt != 2'h2;
    end
  end

  // ==========================================================
  // link drive
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      h_r         <= CNT_W'(SRC_RESET_H);
      v_r         <= CNT_W'(ACT_LN + SRC_RESET_V);
      running_r   <= 1'b0;
      strobe_r    <= 1'b0;
      data_r      <= BLACK;
      frame_start <= 1'b0;
      underrun    <= 1'b0;
    end else begin
      frame_start <= fall & frame_begin & run;
      underrun    <= underrun | (fall & active_nxt & ~have_word);
      if (fall) begin
        h_r       <= h_nxt;
        v_r       <= v_nxt;
        running_r <= running_nxt;
        strobe_r  <= active_nxt;
        data_r    <= word_nxt;
      end
    end
  end

  assign link.pixel_clock        = pclk_r;
  assign link.pixel_valid_strobe = strobe_r;
  assign link.pixel_data         = data_r;
endmodule
`default_nettype wire

// [video_panel.sv]
/*
  Panel end of the link: samples the pixel clock with the system clock,
  places pixels from strobe rising edges only and reports black fill runs.
  Assumes the user takes one output word per system cycle without stalling.
*/
`timescale 1ns/1ps
`default_nettype none
module video_panel import video_timing_pkg::*; #(
  parameter int GAP   = GAP_CLOCKS,
  parameter int COLS  = SCREEN_COLS,
  parameter int ROWS  = SCREEN_ROWS
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  video_link_if.panel           link,
  output var  logic             out_valid,
  output var  logic [POS_W-1:0] out_row,
  output var  logic [POS_W-1:0] out_col,
  output var  logic [POS_W:0]   out_run,
  output var  logic [PIX_W-1:0] out_rgb,
  output var  logic             frame_start
);
  if (GAP < 2 || GAP >= (1 << GAP_W) || COLS < 1 || COLS >= (1 << POS_W) ||
      ROWS < 2 || ROWS >= (1 << POS_W)) begin : g_bad_par
    $error("panel parameters out of range");
  end

  // ==========================================================
  // synchronisers
  logic             pclk_s1, pclk_s2, pclk_s3;
  logic             str_s1, str_s2;
  logic [PIX_W-1:0] dat_s1, dat_s2;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      {pclk_s1, pclk_s2, pclk_s3} <= 3'h0;
      {str_s1, str_s2}            <= 2'h0;
      dat_s1                      <= BLACK;
      dat_s2                      <= BLACK;
    end else begin
      {pclk_s1, pclk_s2, pclk_s3} <= {link.pixel_clock, pclk_s1, pclk_s2};
      {str_s1, str_s2}            <= {link.pixel_valid_strobe, str_s1};
      dat_s1                      <= link.pixel_data;
      dat_s2                      <= dat_s1;
    end
  end

  // ==========================================================
  // strobe events, one per pixel clock rise
  panel_state_t     state_r;
  logic             prev_str_r;
  logic [GAP_W-1:0] low_cnt_r;
  logic             gap_seen_r;
  logic [POS_W-1:0] row_r;
  logic [POS_W-1:0] col_r;
  logic [POS_W-1:0] fill_row_r;

  wire             rise    = pclk_s2 & ~pclk_s3;
  wire             srise   = rise & str_s2 & ~prev_str_r;
  wire             sfall   = rise & ~str_s2 & prev_str_r;
  wire             spix    = rise & str_s2;
  wire             gap_hit = rise & ~str_s2 & (low_cnt_r == GAP_W'(GAP - 1));
  wire             row_sat = row_r == POS_W'(ROWS);
  // a rise after the long gap opens a frame at the top row
  wire [POS_W-1:0] row_use = ~srise ? row_r :
                             (gap_seen_r ? '0 : (row_sat ? row_r : row_r + 1'b1));
  wire [POS_W-1:0] col_use = srise ? '0 : col_r;
  wire             in_scr  = (row_use < POS_W'(ROWS)) & (col_use < POS_W'(COLS));
  wire             live    = state_r != ST_SEEK;
  wire             emit_px = spix & live & in_scr;
  wire             emit_hf = sfall & live & (col_r < POS_W'(COLS)) &
                             (row_r < POS_W'(ROWS));
  wire             emit_vf = (state_r == ST_FILL) & ~srise;
  wire             fill_end = fill_row_r == POS_W'(ROWS - 1);
  wire [POS_W-1:0] next_row = row_sat ? row_r : row_r + 1'b1;

  // ==========================================================
  // placement counters
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prev_str_r <= 1'b0;
      low_cnt_r  <= '0;
      gap_seen_r <= 1'b0;
      row_r      <= '0;
      col_r      <= '0;
    end else if (rise) begin
      prev_str_r <= str_s2;
      if (str_s2) begin
        low_cnt_r <= '0;
      end else if (low_cnt_r != GAP_W'(GAP - 1)) begin
        low_cnt_r <= low_cnt_r + 1'b1;
      end
      if (gap_hit) begin
        gap_seen_r <= 1'b1;
      end else if (srise) begin
        gap_seen_r <= 1'b0;
      end
      if (srise) begin
        row_r <= row_use;
        col_r <= POS_W'(1);
      end else if (spix && col_r != POS_W'(COLS)) begin
        col_r <= col_r + 1'b1;
      end
    end
  end

  // ==========================================================
  // seek, run and bottom fill
  // the bottom fill runs at system rate, far inside the vertical blanking
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r    <= ST_SEEK;
      fill_row_r <= '0;
    end else begin
      case (state_r)
        ST_SEEK: begin
          if (gap_hit) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (gap_hit && !gap_seen_r && next_row < POS_W'(ROWS)) begin
            state_r    <= ST_FILL;
            fill_row_r <= next_row;
          end
        end
        ST_FILL: begin
          if (srise || fill_end) begin
            state_r <= ST_RUN;
          end else begin
            fill_row_r <= fill_row_r + 1'b1;
          end
        end
        default: state_r <= ST_SEEK;
      endcase
    end
  end

  // ==========================================================
  // output words
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      out_valid   <= 1'b0;
      out_row     <= '0;
      out_col     <= '0;
      out_run     <= '0;
      out_rgb     <= BLACK;
      frame_start <= 1'b0;
    end else begin
      out_valid   <= emit_px | emit_hf | emit_vf;
      frame_start <= srise & gap_seen_r & live;
      if (emit_px) begin
        out_row <= row_use;
        out_col <= col_use;
        out_run <= (POS_W + 1)'(1);
        out_rgb <= dat_s2;
      end else if (emit_hf) begin
        out_row <= row_r;
        out_col <= col_r;
        out_run <= (POS_W + 1)'(COLS) - {1'b0, col_r};
        out_rgb <= BLACK;
      end else if (emit_vf) begin
        out_row <= fill_row_r;
        out_col <= '0;
        out_run <= (POS_W + 1)'(COLS);
        out_rgb <= BLACK;
      end
    end
  end
endmodule
`default_nettype wire

// [video_link_chk.sv]
/*
  Checker on the source-driven pixel link: clock rate, edge alignment, raster counts.
  Assumes two system cycles per pixel clock and the source's shortened counts.
*/
`timescale 1ns/1ps
`default_nettype none
module video_link_chk import video_timing_pkg::*; #(
  parameter int LINE_CLK = LINE_CLOCKS,
  parameter int ACT_CLK  = ACTIVE_CLOCKS,
  parameter int FRAME_LN = FRAME_LINES,
  parameter int ACT_LN   = ACTIVE_LINES
) (
  input wire logic             clock,
  input wire logic             arst_n,
  input wire logic             pixel_clock,
  input wire logic             pixel_valid_strobe,
  input wire logic [PIX_W-1:0] pixel_data
);
  // ==========================================================
  // run lengths in system cycles
  localparam int HI = 2 * ACT_CLK;
  localparam int HB = 2 * (LINE_CLK - ACT_CLK);
  localparam int VB = 2 * (LINE_CLK * (FRAME_LN - ACT_LN + 1) - ACT_CLK);
  localparam int FR = 2 * LINE_CLK * FRAME_LN;
  logic        prev_r;
  logic        armed_r;
  logic [15:0] run_r;
  logic [15:0] frm_r;
  logic [11:0] lines_r;
  wire         rise   = pixel_valid_strobe & ~prev_r;
  wire         fall   = ~pixel_valid_strobe & prev_r;
  // a low run longer than a line can only be vertical blanking
  wire         frm_go = rise & (run_r > 16'(2 * LINE_CLK));
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prev_r  <= 1'b0;
      armed_r <= 1'b0;
      run_r   <= 16'h0000;
      frm_r   <= 16'h0000;
      lines_r <= 12'h000;
    end else begin
      prev_r  <= pixel_valid_strobe;
      armed_r <= armed_r | frm_go;
      run_r   <= (rise | fall) ? 16'h0001 : run_r + 16'h0001;
      frm_r   <= frm_go ? 16'h0001 : frm_r + 16'h0001;
      lines_r <= frm_go ? 12'h001 : lines_r + 12'(rise);
    end
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_pclk_cycle;
    $fell(pixel_clock) ##1 $rose(pixel_clock);
  endsequence
  a_pclk_rate: assert property ($rose(pixel_clock) |=> s_pclk_cycle)
    else $error("pixel clock period is not two cycles");
  a_strobe_align: assert property ($changed(pixel_valid_strobe) |-> $fell(pixel_clock))
    else $error("strobe moved away from a pixel clock fall");
  a_data_align: assert property ($changed(pixel_data) |-> $fell(pixel_clock))
    else $error("data moved away from a pixel clock fall");
  a_blank_black: assert property (!pixel_valid_strobe |-> pixel_data == BLACK)
    else $error("data not black while strobe low");
  a_active_len: assert property (fall |-> run_r == 16'(HI))
    else $error("active run length wrong");
  a_hblank_len: assert property (rise && armed_r && lines_r < 12'(ACT_LN) |-> run_r == 16'(HB))
    else $error("line blanking length wrong");
  a_vblank_len: assert property (rise && armed_r && lines_r == 12'(ACT_LN) |-> run_r == 16'(VB))
    else $error("frame blanking length wrong");
  a_frame_period: assert property (frm_go && armed_r |-> frm_r == 16'(FR))
    else $error("frame period wrong");
endmodule
`default_nettype wire

// [de_only_panel_input_timing_tb.sv]
/*
  Bench for both link ends with shortened raster counts.
  Assumes a second panel whose link the bench drives itself.
*/
`timescale 1ns/1ps
`default_nettype none
module de_only_panel_input_timing_tb import video_timing_pkg::*;;
  localparam int LC = 40;
  localparam int AC = 30;
  localparam int FL = 30;
  localparam int AL = 20;
  localparam int GP = 8 * LC;
  localparam int CO = 64;
  localparam int RO = 40;
  logic             clock;
  logic             arst_n;
  logic             run;
  logic             in_valid;
  logic [PIX_W-1:0] in_data;
  wire              in_ready;
  wire              underrun;
  wire              src_fs;
  wire  [1:0]       ov;
  wire  [1:0]       ofs;
  wire  [POS_W-1:0] orow [2];
  wire  [POS_W-1:0] ocol [2];
  wire  [POS_W:0]   orun [2];
  wire  [PIX_W-1:0] orgb [2];
  logic [60:0]      q0 [$];
  logic [60:0]      q1 [$];
  int               errors;
  int               total_checks;
  int               src_frames;
  video_link_if link [2] ();
  video_source #(.LINE_CLK(LC), .ACT_CLK(AC), .FRAME_LN(FL), .ACT_LN(AL)) i_video_source (
    .clock(clock), .arst_n(arst_n), .run(run), .in_data(in_data), .in_valid(in_valid),
    .in_ready(in_ready), .frame_start(src_fs), .underrun(underrun), .link(link[0]));
  // the second panel hears a link that breaks the gap and window rules on purpose
  for (genvar i = 0; i < 2; i++) begin : g_panel
    video_panel #(.GAP(GP), .COLS(CO), .ROWS(RO)) i_video_panel (
      .clock(clock), .arst_n(arst_n), .link(link[i]), .out_valid(ov[i]), .out_row(orow[i]),
      .out_col(ocol[i]), .out_run(orun[i]), .out_rgb(orgb[i]), .frame_start(ofs[i]));
  end
  video_link_chk #(.LINE_CLK(LC), .ACT_CLK(AC), .FRAME_LN(FL), .ACT_LN(AL)) i_video_link_chk (
    .clock(clock), .arst_n(arst_n), .pixel_clock(link[0].pixel_clock),
    .pixel_valid_strobe(link[0].pixel_valid_strobe), .pixel_data(link[0].pixel_data));
  // ==========================================================
  // helpers
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic complete_run(input bit hung);
    if (hung) errors++;
    $display("checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask
  function automatic logic [60:0] word(input int r, input int c, input int n, input logic [PIX_W-1:0] d);
    return {12'(r), 12'(c), 13'(n), d};
  endfunction
  function automatic logic [PIX_W-1:0] pix(input int r, input int c);
    return {8'(r * 11), 8'(c * 8 + 7), 8'(255 - r - c)};
  endfunction
  task automatic add_frame(input bit dark);
    for (int r = 0; r < AL; r++) begin
      for (int c = 0; c < AC; c++) q0.push_back(word(r, c, 1, dark ? BLACK : pix(r, c)));
      q0.push_back(word(r, AC, CO - AC, BLACK));
    end
    for (int r = AL; r < RO; r++) q0.push_back(word(r, 0, CO, BLACK));
  endtask
  task automatic take(ref logic [60:0] q [$], input int i);
    logic [60:0] got;
    logic [60:0] exp;
    got = {orow[i], ocol[i], orun[i], orgb[i]};
    exp = (q.size() != 0) ? q.pop_front() : ~got;
    check("panel word", 64'(got), 64'(exp));
    check("frame start", 64'(ofs[i]), 64'(exp[60:37] == 24'h0 && exp[36:24] == 13'h1));
  endtask
  always @(negedge clock) begin
    if (ov[0] === 1'b1) take(q0, 0);
    if (ov[1] === 1'b1) take(q1, 1);
    // the source marks a frame in the cycle its first active pixel goes out
    if (src_fs === 1'b1) begin
      src_frames++;
      check("source frame strobe", 64'(link[0].pixel_valid_strobe), 64'h1);
    end
  end
  task automatic push(input logic [PIX_W-1:0] d);
    int n;
    n = 0;
    in_valid = 1'b1;
    in_data  = d;
    while (in_ready !== 1'b1) begin
      @(negedge clock);
      n++;
      if (n > 3000) complete_run(1'b1);
    end
    @(negedge clock);
  endtask
  // changes land on the bench's own pixel clock fall
  task automatic beat(input int n, input logic s, input logic [PIX_W-1:0] d);
    repeat (n) begin
      link[1].pixel_valid_strobe = s;
      link[1].pixel_data         = d;
      #32 link[1].pixel_clock = 1'b1;
      #32 link[1].pixel_clock = 1'b0;
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    int n;
    arst_n = 1'b0;
    run = 1'b1;
    in_valid = 1'b0;
    in_data = BLACK;
    errors = 0;
    total_checks = 0;
    src_frames = 0;
    link[1].pixel_clock = 1'b0;
    link[1].pixel_valid_strobe = 1'b0;
    link[1].pixel_data = BLACK;
    repeat (16) @(negedge clock);
    arst_n = 1'b1;
    add_frame(1'b0);
    add_frame(1'b1);
    fork
      begin
        push(pix(0, 0));
        push(pix(0, 1));
        check("in_ready", 64'(in_ready), 64'h0);
        for (int k = 2; k < AL * AC; k++) push(pix(k / AC, k % AC));
        in_valid = 1'b0;
        n = 0;
        while (underrun !== 1'b1 && n < 4000) begin
          @(negedge clock);
          n++;
        end
        run = 1'b0;
        check("underrun", 64'(underrun), 64'h1);
        $display("test source frames done");
      end
      begin
        beat(5, 1'b0, 24'hFFFFFF);
        for (int c = 0; c < 4; c++) beat(1, 1'b1, pix(9, c));
        beat(GP, 1'b0, ~pix(9, 3));
        for (int r = 0; r < 2; r++) begin
          for (int c = 0; c < 3; c++) begin
            q1.push_back(word(r, c, 1, pix(r, c)));
            beat(1, 1'b1, pix(r, c));
          end
          q1.push_back(word(r, 3, CO - 3, BLACK));
          if (r == 1) for (int b = 2; b < RO; b++) q1.push_back(word(b, 0, CO, BLACK));
          beat(r == 0 ? 2 : GP + 8, 1'b0, ~pix(r, 2));
        end
        $display("test gap detection done");
      end
    join
    n = 0;
    while (q0.size() + q1.size() != 0 && n < 20000) begin
      @(negedge clock);
      n++;
    end
    check("words left", 64'(q0.size() + q1.size()), 64'h0);
    check("source frames", 64'(src_frames), 64'h2);
    repeat (2 * LC * FL) @(negedge clock);
    complete_run(1'b0);
  end
endmodule
`default_nettype wire
